// ---- rtl/dual_prescaled_down_counter.sv ----
// Contract
// - Two independent 8-bit down-counters, each behind its own 6-bit prescaler.
// - Counter A prescaler uses internal clock only; counter B may use external.
// - Each prescaler divides its input by any integer from 1 to 64.
// - Counter decrements on each prescaler pulse; terminal count spans 1 to 256.
// - Both stages at end of count raise that counter's own interrupt request.
// - Software can start, stop, continue or restart each counter from its initial value.
// - Single-pass halts at zero; continuous mode reloads the initial value and continues.
// - Counter values readable anytime without disturbance; prescaler contents never readable.
// - Counter B clock is internal clock divided by four or external input.
// - Timer mode sets input role: clock, retrigger, single trigger, or gate.
// - Analog mode feeds comparator one output into the timer input path.
// - Internal timer clock equals crystal input divided by two in standard mode.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
module dual_prescaled_down_counter (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [timer_pkg::ADDR_W-1:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [timer_pkg::DATA_W-1:0] WDATA_I,
	input wire logic [timer_pkg::DATA_W/8-1:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [timer_pkg::ADDR_W-1:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [timer_pkg::DATA_W-1:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I,
	input wire logic EXT_TIMER_PIN_I,
	input wire logic COMP1_OUT_I,
	output logic TIMER_A_IRQ_O,
	output logic TIMER_B_IRQ_O,
	output logic IRQ_O
);
	import timer_pkg::*;

	// ************************************************************
	// Declarations
	// ************************************************************
	logic awready_q, wready_q, bvalid_q, w_lane0_q, wr_fire, wr_en, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q, pin_s_q, cmp_s_q, div_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [DATA_W-1:0] w_data_q, rdata_q, rd_word;
	logic run_a_q, cont_a_q, run_b_q, cont_b_q, load_a_q, load_b_q;
	logic src_ext_q, analog_q, irq_q;
	logic [PRE_W-1:0] pre_a_q, pre_b_q;
	logic [CNT_W-1:0] init_a_q, init_b_q, count_a, count_b;
	pin_role_e role_q;
	logic [NUM_IRQ-1:0] irq_st_q, irq_en_q, irq_clr, irq_ev;
	logic timer_input, tin_d_q, tin_edge, tick4, tick_b, trig_b;
	logic act_a, act_b, timer_a_irq, timer_b_irq;

	// Decode shared by the read and the write path
	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		is_mapped = addr inside {OFF_CTRL, OFF_PRE_A, OFF_INIT_A, OFF_PRE_B, OFF_INIT_B,
			OFF_COUNT_A, OFF_COUNT_B, OFF_TMODE, OFF_IRQ_STAT, OFF_IRQ_CLR, OFF_IRQ_EN};
	endfunction : is_mapped

	// ************************************************************
	// AXI4-Lite write channel
	// ************************************************************

	// Address and data are taken in either order, one write at a time
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_lane0_q <= 1'b0;
		end else begin
			if (AWVALID_I && awready_q) begin
				aw_addr_q <= AWADDR_I;
				awready_q <= 1'b0;
			end
			if (WVALID_I && wready_q) begin
				w_data_q <= WDATA_I;
				w_lane0_q <= WSTRB_I[0];
				wready_q <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && BREADY_I) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// All fields sit in byte lane 0, so that lane alone gates the store
	assign wr_fire = ~awready_q & ~wready_q & ~bvalid_q;
	assign wr_en = wr_fire & w_lane0_q;

	// ************************************************************
	// AXI4-Lite read channel
	// ************************************************************

	// Read mux; prescaler reload values and the clear word read as zero
	always_comb begin
		rd_word = '0;
		unique case (ARADDR_I)
			OFF_CTRL: begin
				rd_word[CTRL_A_RUN] = run_a_q;
				rd_word[CTRL_A_CONT] = cont_a_q;
				rd_word[CTRL_B_RUN] = run_b_q;
				rd_word[CTRL_B_CONT] = cont_b_q;
				rd_word[CTRL_A_ACTIVE] = act_a;
				rd_word[CTRL_B_ACTIVE] = act_b;
			end
			OFF_INIT_A: rd_word[CNT_W-1:0] = init_a_q;
			OFF_INIT_B: rd_word[CNT_W-1:0] = init_b_q;
			OFF_COUNT_A: rd_word[CNT_W-1:0] = count_a;
			OFF_COUNT_B: rd_word[CNT_W-1:0] = count_b;
			OFF_TMODE: begin
				rd_word[TMODE_ROLE_LO+:2] = role_q;
				rd_word[TMODE_SRC_EXT] = src_ext_q;
				rd_word[TMODE_ANALOG] = analog_q;
			end
			OFF_IRQ_STAT: rd_word[NUM_IRQ-1:0] = irq_st_q;
			OFF_IRQ_EN: rd_word[NUM_IRQ-1:0] = irq_en_q;
			default: rd_word = '0;
		endcase
	end

	// Read answer registered on the same edge that takes the address
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
		end else begin
			if (ARVALID_I && arready_q) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= is_mapped(ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
			end
			if (rvalid_q && RREADY_I) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Control and configuration registers
	// ************************************************************

	// Run bits start, stop and continue; counters keep value while stopped
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			run_a_q <= 1'b0;
			cont_a_q <= 1'b0;
			run_b_q <= 1'b0;
			cont_b_q <= 1'b0;
			pre_a_q <= '0;
			pre_b_q <= '0;
			init_a_q <= '0;
			init_b_q <= '0;
			role_q <= ROLE_CLOCK;
			src_ext_q <= 1'b0;
			analog_q <= 1'b0;
		end else if (wr_en) begin
			unique case (aw_addr_q)
				OFF_CTRL: begin
					run_a_q <= w_data_q[CTRL_A_RUN];
					cont_a_q <= w_data_q[CTRL_A_CONT];
					run_b_q <= w_data_q[CTRL_B_RUN];
					cont_b_q <= w_data_q[CTRL_B_CONT];
				end
				OFF_PRE_A: pre_a_q <= w_data_q[PRE_W-1:0];
				OFF_PRE_B: pre_b_q <= w_data_q[PRE_W-1:0];
				OFF_INIT_A: init_a_q <= w_data_q[CNT_W-1:0];
				OFF_INIT_B: init_b_q <= w_data_q[CNT_W-1:0];
				OFF_TMODE: begin
					role_q <= pin_role_e'(w_data_q[TMODE_ROLE_LO+:2]);
					src_ext_q <= w_data_q[TMODE_SRC_EXT];
					analog_q <= w_data_q[TMODE_ANALOG];
				end
				default: ;
			endcase
		end
	end

	// Restart bits act once and never store
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			load_a_q <= 1'b0;
			load_b_q <= 1'b0;
		end else begin
			load_a_q <= wr_en & (aw_addr_q == OFF_CTRL) & w_data_q[CTRL_A_RESTART];
			load_b_q <= wr_en & (aw_addr_q == OFF_CTRL) & w_data_q[CTRL_B_RESTART];
		end
	end

	// ************************************************************
	// Timer input path
	// ************************************************************

	// Two-stage synchronisers; only the second stage feeds logic
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pin_s_q <= '0;
			cmp_s_q <= '0;
			tin_d_q <= 1'b0;
		end else begin
			pin_s_q <= {pin_s_q[0], EXT_TIMER_PIN_I};
			cmp_s_q <= {cmp_s_q[0], COMP1_OUT_I};
			tin_d_q <= timer_input;
		end
	end

	// Comparator replaces the raw pin while analog mode is on
	assign timer_input = analog_q ? cmp_s_q[1] : pin_s_q[1];
	assign tin_edge = timer_input & ~tin_d_q;

	// CLK_I is the internal clock, already the crystal divided by two
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + DIV4_STEP;
		end
	end

	assign tick4 = (div_q == DIV4_LAST);

	// Role of the input; triggers restart, non-retrigger only when idle
	always_comb begin
		tick_b = tick4;
		trig_b = 1'b0;
		if (src_ext_q) begin
			unique case (role_q)
				ROLE_CLOCK: tick_b = tin_edge;
				ROLE_RETRIG: trig_b = tin_edge;
				ROLE_NONRETRIG: trig_b = tin_edge & ~act_b;
				ROLE_GATE: tick_b = tick4 & timer_input;
			endcase
		end
	end

	// ************************************************************
	// Counter channels
	// ************************************************************

	// Counter A sees only the internal divided clock
	timer_channel #(
		.CNT_W(CNT_W),
		.PRE_W(PRE_W)
	) u_timer_a (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.tick_i(tick4),
		.run_i(run_a_q),
		.load_i(load_a_q),
		.cont_i(cont_a_q),
		.pre_i(pre_a_q),
		.init_i(init_a_q),
		.count_o(count_a),
		.active_o(act_a),
		.eoc_o(timer_a_irq)
	);

	// Counter B clock follows the mode register
	timer_channel #(
		.CNT_W(CNT_W),
		.PRE_W(PRE_W)
	) u_timer_b (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.tick_i(tick_b),
		.run_i(run_b_q),
		.load_i(load_b_q | trig_b),
		.cont_i(cont_b_q),
		.pre_i(pre_b_q),
		.init_i(init_b_q),
		.count_o(count_b),
		.active_o(act_b),
		.eoc_o(timer_b_irq)
	);

	// Request lines are the channels' own one-cycle flops
	assign TIMER_A_IRQ_O = timer_a_irq;
	assign TIMER_B_IRQ_O = timer_b_irq;

	// ************************************************************
	// Interrupt status, clear and enable
	// ************************************************************

	assign irq_ev[IRQ_A] = timer_a_irq;
	assign irq_ev[IRQ_B] = timer_b_irq;
	assign irq_clr = (wr_en && aw_addr_q == OFF_IRQ_CLR) ? w_data_q[NUM_IRQ-1:0] : '0;

	// A new event in the clearing cycle survives the clear
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			irq_st_q <= '0;
			irq_en_q <= '0;
			irq_q <= 1'b0;
		end else begin
			irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
			if (wr_en && aw_addr_q == OFF_IRQ_EN) begin
				irq_en_q <= w_data_q[NUM_IRQ-1:0];
			end
			irq_q <= |(irq_st_q & irq_en_q);
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign AWREADY_O = awready_q;
	assign WREADY_O = wready_q;
	assign BVALID_O = bvalid_q;
	assign BRESP_O = bresp_q;
	assign ARREADY_O = arready_q;
	assign RVALID_O = rvalid_q;
	assign RRESP_O = rresp_q;
	assign RDATA_O = rdata_q;
	assign IRQ_O = irq_q;

	// ************************************************************
	// Checks
	// ************************************************************
	// Divide-by-four cadence: three quiet cycles, then a tick
	sequence s_quiet3;
		!tick4 [*3] ##1 tick4;
	endsequence
	AST_DIV4: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		tick4 |=> s_quiet3)
		else $error("internal divide by four lost its cadence");
	AST_IRQ_PULSE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		TIMER_A_IRQ_O |=> !TIMER_A_IRQ_O)
		else $error("counter A request longer than one cycle");
	AST_IRQ_B_PULSE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		TIMER_B_IRQ_O |=> !TIMER_B_IRQ_O)
		else $error("counter B request longer than one cycle");
	AST_STATUS_SET: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		TIMER_B_IRQ_O |=> irq_st_q[IRQ_B] ##1 IRQ_O || !irq_en_q[IRQ_B])
		else $error("counter B event not latched or not signalled");
	// The step that ends the count is one edge before the pulse
	AST_A_INTERNAL: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		TIMER_A_IRQ_O |-> $past(tick4))
		else $error("counter A advanced without an internal tick");
	AST_ANALOG: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		analog_q && $stable(analog_q) |-> timer_input == cmp_s_q[1])
		else $error("analog mode did not select the comparator");
	AST_NONRETRIG: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		act_b && !load_b_q && src_ext_q && role_q == ROLE_NONRETRIG |-> !trig_b)
		else $error("non-retriggerable input restarted a running count");
	AST_BHOLD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
		else $error("write response dropped before it was taken");

endmodule : dual_prescaled_down_counter

// ---- rtl/timer_channel.sv ----
module timer_channel #(
	parameter int CNT_W = timer_pkg::CNT_W,
	parameter int PRE_W = timer_pkg::PRE_W
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic load_i,
	input wire logic cont_i,
	input wire logic [PRE_W-1:0] pre_i,
	input wire logic [CNT_W-1:0] init_i,
	output logic [CNT_W-1:0] count_o,
	output logic active_o,
	output logic eoc_o
);
	import timer_pkg::*;

	localparam logic [PRE_W-1:0] P_END = PRE_W'(END_VAL);
	localparam logic [PRE_W-1:0] P_DEC = PRE_W'(DEC_VAL);
	localparam logic [CNT_W-1:0] C_END = CNT_W'(END_VAL);
	localparam logic [CNT_W-1:0] C_DEC = CNT_W'(DEC_VAL);

	logic [PRE_W-1:0] pre_q;
	logic [CNT_W-1:0] cnt_q;
	logic done_q;
	logic eoc_q;
	logic step;
	logic pre_end;
	logic cnt_end;

	// A restart always wins over a pending step
	assign step = tick_i & run_i & ~done_q & ~load_i;
	assign pre_end = (pre_q == P_END);
	assign cnt_end = (cnt_q == C_END);

	// Prescaler and counter; a zero load wraps, giving 64 and 256
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_q <= '0;
			cnt_q <= '0;
			done_q <= 1'b1;
		end else if (load_i) begin
			pre_q <= pre_i;
			cnt_q <= init_i;
			done_q <= 1'b0;
		end else if (step) begin
			if (pre_end) begin
				pre_q <= pre_i;
				if (cnt_end) begin
					cnt_q <= cont_i ? init_i : cnt_q - C_DEC;
					done_q <= ~cont_i;
				end else begin
					cnt_q <= cnt_q - C_DEC;
				end
			end else begin
				pre_q <= pre_q - P_DEC;
			end
		end
	end

	// End of count only when both stages expire together
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eoc_q <= 1'b0;
		end else begin
			eoc_q <= step & pre_end & cnt_end;
		end
	end

	assign count_o = cnt_q;
	assign active_o = ~done_q;
	assign eoc_o = eoc_q;

	// ************************************************************
	// Checks
	// ************************************************************
	AST_EOC_CAUSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		eoc_q |-> $past(pre_q) == P_END && $past(cnt_q) == C_END && $past(step))
		else $error("end of count without both stages at one");

	AST_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!step && !load_i |=> $stable(cnt_q) && $stable(pre_q))
		else $error("count moved without a step");

	AST_HALT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		eoc_q && !$past(cont_i) && !load_i |-> !active_o && cnt_q == '0)
		else $error("single pass did not halt at zero");

	AST_RELOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		eoc_q && $past(cont_i) |-> cnt_q == $past(init_i) && active_o)
		else $error("continuous mode did not reload");

	AST_PRE_RELOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		step && pre_end |=> pre_q == $past(pre_i))
		else $error("prescaler not reloaded at its end");

endmodule : timer_channel

// ---- shared/timer_pkg.sv ----
package timer_pkg;

	// ************************************************************
	// Bus and datapath widths
	// ************************************************************
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int CNT_W = 8;
	localparam int PRE_W = 6;
	localparam int NUM_IRQ = 2;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_PRE_A = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_INIT_A = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_PRE_B = 6'h0c;
	localparam logic [ADDR_W-1:0] OFF_INIT_B = 6'h10;
	localparam logic [ADDR_W-1:0] OFF_COUNT_A = 6'h14;
	localparam logic [ADDR_W-1:0] OFF_COUNT_B = 6'h18;
	localparam logic [ADDR_W-1:0] OFF_TMODE = 6'h1c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 6'h20;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 6'h24;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 6'h28;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CTRL_A_RUN = 0;
	localparam int CTRL_A_CONT = 1;
	localparam int CTRL_A_RESTART = 2;
	localparam int CTRL_B_RUN = 3;
	localparam int CTRL_B_CONT = 4;
	localparam int CTRL_B_RESTART = 5;
	localparam int CTRL_A_ACTIVE = 6;
	localparam int CTRL_B_ACTIVE = 7;
	localparam int TMODE_ROLE_LO = 0;
	localparam int TMODE_SRC_EXT = 2;
	localparam int TMODE_ANALOG = 3;
	localparam int IRQ_A = 0;
	localparam int IRQ_B = 1;

	// ************************************************************
	// Counting constants and bus answers
	// ************************************************************
	localparam int END_VAL = 1;
	localparam int DEC_VAL = 1;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	localparam logic [1:0] DIV4_STEP = 2'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Roles of the external timer input
	typedef enum logic [1:0] {
		ROLE_CLOCK = 2'h0,
		ROLE_RETRIG = 2'h1,
		ROLE_NONRETRIG = 2'h2,
		ROLE_GATE = 2'h3
	} pin_role_e;

endpackage : timer_pkg

// ---- test/ext_pin_model.sv ----
module ext_pin_model (
	input wire logic clk_i,
	output logic pin_o,
	output logic comp_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// Both lines idle low from time zero
	initial begin
		pin_o = 1'b0;
		comp_o = 1'b0;
	end

	// One pulse with four clocks per phase, so the two-flop sync sees both levels
	task automatic pulse(input bit use_comp);
		repeat (4) @(posedge clk_i);
		comp_o <= use_comp;
		pin_o <= !use_comp;
		repeat (4) @(posedge clk_i);
		pin_o <= 1'b0;
		comp_o <= 1'b0;
	endtask : pulse

	// Held level for the gate role
	task automatic level(input bit lvl);
		@(posedge clk_i);
		pin_o <= lvl;
	endtask : level
endmodule : ext_pin_model

// ---- test/tb_dual_prescaled_down_counter.sv ----
module tb_dual_prescaled_down_counter;
	timeunit 1ns;
	timeprecision 1ns;
	import timer_pkg::*;
`define CHK(a, b) chk((a) === (b), `__LINE__)
	logic clk, rst_n, awv, wv, bready, arv, rready, pin, comp;
	logic awready, wready, bvalid, arready, rvalid, irq_a, irq_b, irq;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata, v, w;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [31:0] seed;
	int num_errors, n_compared, c, p, n, e, m;
	logic [ADDR_W-1:0] offs [8] = '{OFF_CTRL, OFF_INIT_A, OFF_INIT_B, OFF_COUNT_A,
		OFF_COUNT_B, OFF_TMODE, OFF_IRQ_STAT, OFF_IRQ_EN};

	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	dual_prescaled_down_counter uut (
		.CLK_I(clk), .RST_N_I(rst_n), .AWADDR_I(awaddr), .AWVALID_I(awv),
		.AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wv),
		.WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
		.ARADDR_I(araddr), .ARVALID_I(arv), .ARREADY_O(arready), .RDATA_O(rdata),
		.RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
		.EXT_TIMER_PIN_I(pin), .COMP1_OUT_I(comp), .TIMER_A_IRQ_O(irq_a),
		.TIMER_B_IRQ_O(irq_b), .IRQ_O(irq)
	);

	ext_pin_model pm (.clk_i(clk), .pin_o(pin), .comp_o(comp));

	// ************************************************************
	// Checking and bus tasks
	// ************************************************************
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task automatic chk(input bit ok, input int ln);
		n_compared++;
		if (!ok) begin
			num_errors++;
			$display("ERROR %0t mismatch at line %0d", $time, ln);
		end
	endtask : chk

	// A used-up wait is fatal to the run, since later steps lose their footing
	task automatic bound(input int k, input int lim);
		if (k >= lim) begin
			num_errors++;
			$display("ERROR %0t wait limit reached", $time);
			finish_test();
		end
	endtask : bound

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Write: AW and W offered together, each dropped once taken
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
		input logic [1:0] er = RESP_OKAY, input logic [3:0] st = 4'hf);
		int k;
		logic [31:0] r;
		k = 0;
		r = rnd();
		@(posedge clk);
		awaddr <= a;
		wdata <= {r[31:8], d}; // Unused upper bits carry noise
		wstrb <= {r[3:1], st[0]};
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= r[4];
		do begin
			@(posedge clk);
			k++;
			if (awready === 1'b1) awv <= 1'b0;
			if (wready === 1'b1) wv <= 1'b0;
			// Late ready makes the slave hold its response
			if (k > r[6:5] && bready !== 1'b1) bready <= 1'b1;
		end while (!(bvalid === 1'b1 && bready === 1'b1) && k < 60);
		bound(k, 60);
		bready <= 1'b0;
		`CHK(bresp, er);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
		input logic [1:0] er = RESP_OKAY);
		int k;
		logic [31:0] r;
		k = 0;
		r = rnd();
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= r[0];
		do begin
			@(posedge clk);
			k++;
			if (arready === 1'b1) arv <= 1'b0;
			if (k > r[2:1] && rready !== 1'b1) rready <= 1'b1;
		end while (!(rvalid === 1'b1 && rready === 1'b1) && k < 60);
		bound(k, 60);
		d = rdata;
		rready <= 1'b0;
		`CHK(rresp, er);
	endtask : rd

	// Edges up to the end-of-count pulse, then its one-cycle width
	task automatic wait_irq(input int ch, output int cyc);
		cyc = 0;
		do begin
			@(posedge clk);
			cyc++;
		end while ((ch ? irq_b : irq_a) !== 1'b1 && cyc < 70000);
		bound(cyc, 70000);
		@(posedge clk);
		`CHK(ch ? irq_b : irq_a, 1'b0);
	endtask : wait_irq

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rst_n = 1'b0;
		{awv, wv, bready, arv, rready} = 5'h00;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hf;
		num_errors = 0;
		n_compared = 0;
		seed = 32'h691c8fb0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		foreach (offs[i]) begin
			rd(offs[i], v);
			`CHK(v, 32'h0);
		end
		wr(OFF_PRE_A, 8'h05);
		rd(OFF_PRE_A, v);
		`CHK(v, 32'h0);
		wr(OFF_COUNT_A, 8'h33);
		wr(OFF_INIT_A, 8'h11, RESP_OKAY, 4'h0);
		rd(OFF_COUNT_A, v);
		`CHK(v, 32'h0);
		rd(OFF_INIT_A, v);
		`CHK(v, 32'h0);
		wr(6'h2c, 8'h01, RESP_SLVERR);
		rd(6'h3c, v, RESP_SLVERR);
		`CHK(v, 32'h0);
		$display("test registers done");
		// Single pass with zero loaded counter, interrupt masked first
		wr(OFF_PRE_A, 8'h01);
		wr(OFF_INIT_A, 8'h00);
		wr(OFF_CTRL, 8'h05);
		wait_irq(0, c);
		`CHK(c >= 1016 && c <= 1032, 1'b1);
		rd(OFF_COUNT_A, v);
		`CHK(v, 32'h0);
		rd(OFF_CTRL, v);
		`CHK(v[7:0], 8'h01);
		rd(OFF_IRQ_STAT, v);
		`CHK(v[1:0], 2'b01);
		`CHK(irq, 1'b0);
		wr(OFF_IRQ_EN, 8'h03);
		repeat (3) @(posedge clk);
		`CHK(irq, 1'b1);
		wr(OFF_IRQ_CLR, 8'h01);
		repeat (3) @(posedge clk);
		`CHK(irq, 1'b0);
		rd(OFF_IRQ_STAT, v);
		`CHK(v[1:0], 2'b00);
		$display("test single pass done");
		// Random modulo-N periods on both channels, internal clock over four
		for (int i = 0; i < 4; i++) begin
			p = rnd() % 64;
			n = rnd() % 6 + 1;
			e = 4 * (p == 0 ? 64 : p) * n;
			wr(i % 2 ? OFF_PRE_B : OFF_PRE_A, p[7:0]);
			wr(i % 2 ? OFF_INIT_B : OFF_INIT_A, n[7:0]);
			wr(OFF_CTRL, i % 2 ? 8'h38 : 8'h07);
			wait_irq(i % 2, c);
			wait_irq(i % 2, c);
			`CHK(c + 1, e);
		end
		$display("test continuous done");
		// Stop holds, continue resumes, restart reloads
		wr(OFF_PRE_A, 8'h04);
		wr(OFF_INIT_A, 8'd100);
		wr(OFF_CTRL, 8'h05);
		repeat (100) @(posedge clk);
		wr(OFF_CTRL, 8'h00);
		rd(OFF_COUNT_A, v);
		e = 100 - v[7:0];
		`CHK(e >= 4 && e <= 9, 1'b1);
		repeat (50) @(posedge clk);
		rd(OFF_COUNT_A, w);
		`CHK(w, v);
		wr(OFF_CTRL, 8'h01);
		repeat (64) @(posedge clk);
		rd(OFF_COUNT_A, w);
		e = v[7:0] - w[7:0];
		`CHK(e >= 3 && e <= 6, 1'b1);
		wr(OFF_CTRL, 8'h05);
		rd(OFF_COUNT_A, w);
		`CHK(w[7:0] >= 8'd98, 1'b1);
		wr(OFF_CTRL, 8'h00);
		$display("test stop continue done");
		// External clock role on channel B, driven by the model's pulses, counts tracked in m
		wr(OFF_TMODE, 8'h04);
		wr(OFF_PRE_B, 8'h01);
		wr(OFF_INIT_B, 8'h03);
		wr(OFF_IRQ_CLR, 8'h03);
		wr(OFF_CTRL, 8'h28);
		m = 3;
		repeat (3) begin
			pm.pulse(0);
			m--;
			repeat (4) @(posedge clk);
			rd(OFF_COUNT_B, v);
			`CHK(v, m);
		end
		rd(OFF_IRQ_STAT, v);
		`CHK(v[1:0], 2'b10);
		// Gate role: internal ticks pass only while the pin is high
		wr(OFF_TMODE, 8'h07);
		wr(OFF_INIT_B, 8'd200);
		wr(OFF_CTRL, 8'h28);
		rd(OFF_COUNT_B, v);
		`CHK(v[7:0], 8'd200);
		repeat (40) @(posedge clk);
		rd(OFF_COUNT_B, w);
		`CHK(w, v);
		pm.level(1);
		repeat (40) @(posedge clk);
		pm.level(0);
		repeat (4) @(posedge clk);
		rd(OFF_COUNT_B, w);
		e = v[7:0] - w[7:0];
		`CHK(e >= 8 && e <= 12, 1'b1);
		// Analog mode: comparator replaces the pin
		wr(OFF_TMODE, 8'h0c);
		wr(OFF_INIT_B, 8'h05);
		wr(OFF_CTRL, 8'h28);
		pm.pulse(0);
		pm.pulse(1);
		pm.pulse(1);
		repeat (4) @(posedge clk);
		rd(OFF_COUNT_B, v);
		`CHK(v, 32'd3);
		// Retriggerable restarts an active count, non-retriggerable does not
		wr(OFF_PRE_B, 8'h00);
		wr(OFF_INIT_B, 8'h09);
		wr(OFF_TMODE, 8'h05);
		wr(OFF_CTRL, 8'h08);
		pm.pulse(0);
		repeat (4) @(posedge clk);
		rd(OFF_COUNT_B, v);
		`CHK(v, 32'd9);
		wr(OFF_TMODE, 8'h06);
		wr(OFF_INIT_B, 8'h07);
		pm.pulse(0);
		repeat (4) @(posedge clk);
		rd(OFF_COUNT_B, v);
		`CHK(v, 32'd9);
		$display("test timer input done");
		finish_test();
	end
endmodule : tb_dual_prescaled_down_counter
